// ==== hdl/psd_pkg.sv ====
// Purpose: Shared constants and types for the packed SIMD opcode decoder
// Assumes: Byte stream from the fetch queue, one byte per cycle when valid
// Notes:   Opcode bytes and ModR/M field positions are named here once
package psd_pkg;
	localparam logic [7:0] ESCAPE_BYTE   = 8'h0F;
	localparam logic [7:0] OP_EMPTY      = 8'h77;
	localparam logic [7:0] OP_MOVE_32BIT_IN    = 8'h6E;
	localparam logic [7:0] OP_MOVE_32BIT_OUT   = 8'h7E;
	localparam logic [7:0] OP_MOVE_64BIT_IN    = 8'h6F;
	localparam logic [7:0] OP_MOVE_64BIT_OUT   = 8'h7F;
	localparam logic [7:0] OP_PACK_SDW   = 8'h6B;
	localparam logic [7:0] OP_PACK_SWB   = 8'h63;
	localparam logic [7:0] OP_PACK_UWB   = 8'h67;
	localparam logic [7:0] OP_ADD_B      = 8'hFC;
	localparam logic [7:0] OP_ADD_W      = 8'hFD;
	localparam logic [7:0] OP_ADD_D      = 8'hFE;
	localparam logic [7:0] OP_ADDS_B     = 8'hEC;
	localparam logic [7:0] OP_ADDS_W     = 8'hED;
	localparam logic [7:0] OP_ADDUS_B    = 8'hDC;
	localparam logic [7:0] OP_ADDUS_W    = 8'hDD;
	localparam logic [7:0] OP_AND        = 8'hDB;
	localparam logic [7:0] OP_ANDN       = 8'hDF;
	localparam logic [7:0] OP_OR         = 8'hEB;
	localparam logic [7:0] OP_XOR        = 8'hEF;
	localparam logic [7:0] OP_CEQ_B      = 8'h74;
	localparam logic [7:0] OP_CEQ_W      = 8'h75;
	localparam logic [7:0] OP_CEQ_D      = 8'h76;
	localparam logic [7:0] OP_CGT_B      = 8'h64;
	localparam logic [7:0] OP_CGT_W      = 8'h65;
	localparam logic [7:0] OP_CGT_D      = 8'h66;
	localparam logic [7:0] OP_MADD       = 8'hF5;
	localparam logic [7:0] OP_MULH       = 8'hE5;
	localparam logic [7:0] OP_MULL       = 8'hD5;
	localparam logic [7:0] OP_SLL_W      = 8'hF1;
	localparam logic [7:0] OP_SLL_D      = 8'hF2;
	localparam logic [7:0] OP_SLL_Q      = 8'hF3;
	localparam logic [7:0] OP_SRA_W      = 8'hE1;
	localparam logic [7:0] OP_SRA_D      = 8'hE2;
	localparam logic [7:0] OP_SRL_W      = 8'hD1;
	localparam logic [7:0] OP_SRL_D      = 8'hD2;
	localparam logic [7:0] OP_SRL_Q      = 8'hD3;
	localparam logic [7:0] OP_IMM_W      = 8'h71;
	localparam logic [7:0] OP_IMM_D      = 8'h72;
	localparam logic [7:0] OP_IMM_Q      = 8'h73;
	localparam logic [7:0] OP_SUB_B      = 8'hF8;
	localparam logic [7:0] OP_SUB_W      = 8'hF9;
	localparam logic [7:0] OP_SUB_D      = 8'hFA;
	localparam logic [7:0] OP_SUBS_B     = 8'hE8;
	localparam logic [7:0] OP_SUBS_W     = 8'hE9;
	localparam logic [7:0] OP_SUBUS_B    = 8'hD8;
	localparam logic [7:0] OP_SUBUS_W    = 8'hD9;
	localparam logic [7:0] OP_UNPH_B     = 8'h68;
	localparam logic [7:0] OP_UNPH_W     = 8'h69;
	localparam logic [7:0] OP_UNPH_D     = 8'h6A;
	localparam logic [7:0] OP_UNPL_B     = 8'h60;
	localparam logic [7:0] OP_UNPL_W     = 8'h61;
	localparam logic [7:0] OP_UNPL_D     = 8'h62;

	// ModR/M layout and the shift selects of the immediate groups
	localparam int         MOD_HI        = 7;
	localparam int         MOD_LO        = 6;
	localparam int         REG_HI        = 5;
	localparam int         REG_LO        = 3;
	localparam int         RM_HI         = 2;
	localparam int         RM_LO         = 0;
	localparam logic [1:0] MOD_REGISTER  = 2'h3;
	localparam logic [1:0] MOD_NO_DISP   = 2'h0;
	localparam logic [1:0] MOD_DISP8     = 2'h1;
	localparam logic [2:0] RM_SIB        = 3'h4;
	localparam logic [2:0] RM_DISP32     = 3'h5;
	localparam logic [2:0] SIB_BASE_NONE = 3'h5;
	localparam logic [2:0] REG_SHL       = 3'h6;
	localparam logic [2:0] REG_SHRA      = 3'h4;
	localparam logic [2:0] REG_SHRL      = 3'h2;
	localparam logic [2:0] DISP8_LEN     = 3'h1;
	localparam logic [2:0] DISP32_LEN    = 3'h4;

	// Decoded packed operations
	typedef enum logic [5:0] {
		PO_NONE, PO_EMPTY_PACKED_STATE, PO_MOVE_32BIT_IN, PO_MOVE_32BIT_OUT,
		PO_MOVE_64BIT_IN, PO_MOVE_64BIT_OUT, PO_PACK_SIGNED_DWORD_TO_WORD,
		PO_PACK_SIGNED_WORD_TO_BYTE, PO_PACK_UNSIGNED_WORD_TO_BYTE,
		PO_ADD_WRAP_BYTE, PO_ADD_WRAP_WORD, PO_ADD_WRAP_DWORD,
		PO_ADD_SAT_SIGNED_BYTE, PO_ADD_SAT_SIGNED_WORD,
		PO_ADD_SAT_UNSIGNED_BYTE, PO_ADD_SAT_UNSIGNED_WORD,
		PO_BITWISE_AND_64, PO_BITWISE_AND_NOT_64, PO_BITWISE_OR_64, PO_BITWISE_XOR_64,
		PO_COMPARE_EQUAL_BYTE, PO_COMPARE_EQUAL_WORD, PO_COMPARE_EQUAL_DWORD,
		PO_COMPARE_GREATER_BYTE, PO_COMPARE_GREATER_WORD, PO_COMPARE_GREATER_DWORD,
		PO_MULTIPLY_ADD_WORDS, PO_MULTIPLY_HIGH_WORD, PO_MULTIPLY_LOW_WORD,
		PO_SHIFT_LEFT_WORD, PO_SHIFT_LEFT_DWORD, PO_SHIFT_LEFT_QWORD,
		PO_SHIFT_RIGHT_ARITH_WORD, PO_SHIFT_RIGHT_ARITH_DWORD,
		PO_SHIFT_RIGHT_LOGIC_WORD, PO_SHIFT_RIGHT_LOGIC_DWORD, PO_SHIFT_RIGHT_LOGIC_QWORD,
		PO_SUB_WRAP_BYTE, PO_SUB_WRAP_WORD, PO_SUB_WRAP_DWORD,
		PO_SUB_SAT_SIGNED_BYTE, PO_SUB_SAT_SIGNED_WORD,
		PO_SUB_SAT_UNSIGNED_BYTE, PO_SUB_SAT_UNSIGNED_WORD,
		PO_INTERLEAVE_HIGH_BYTES, PO_INTERLEAVE_HIGH_WORDS, PO_INTERLEAVE_HIGH_DWORDS,
		PO_INTERLEAVE_LOW_BYTES, PO_INTERLEAVE_LOW_WORDS, PO_INTERLEAVE_LOW_DWORDS
	} psd_op_t;

	// Operand form of a second byte
	typedef enum logic [1:0] {
		FM_NONE  = 2'h0,
		FM_MODRM = 2'h1,
		FM_IMM   = 2'h2
	} psd_form_t;

	// One decoded instruction handed to the packed datapath
	typedef struct packed {
		psd_op_t    op;
		logic [7:0] modrm;
		logic [7:0] sib;
		logic       sibPresent;
		logic [7:0] imm;
		logic       immPresent;
	} psd_dec_t;
endpackage : psd_pkg

// ==== hdl/psd_op_table.sv ====
// Purpose: Registered lookup of a second opcode byte into a packed operation
// Assumes: Looked up one cycle before the result is needed
// Notes:   Unlisted bytes come out as PO_NONE with form FM_NONE
`timescale 1ns/1ps
module psd_op_table
	import psd_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      sys_rst,
	input  wire logic      lookEn,
	input  wire logic [7:0] opByte,
	output psd_op_t        opOut,
	output psd_form_t      formOut
);
	psd_op_t   opNxt;
	psd_form_t formNxt;

	// Second byte map
	always_comb begin
		formNxt = FM_MODRM;
		case (opByte)
			OP_EMPTY:    opNxt = PO_EMPTY_PACKED_STATE;
			OP_MOVE_32BIT_IN:  opNxt = PO_MOVE_32BIT_IN;
			OP_MOVE_32BIT_OUT: opNxt = PO_MOVE_32BIT_OUT;
			OP_MOVE_64BIT_IN:  opNxt = PO_MOVE_64BIT_IN;
			OP_MOVE_64BIT_OUT: opNxt = PO_MOVE_64BIT_OUT;
			OP_PACK_SDW: opNxt = PO_PACK_SIGNED_DWORD_TO_WORD;
			OP_PACK_SWB: opNxt = PO_PACK_SIGNED_WORD_TO_BYTE;
			OP_PACK_UWB: opNxt = PO_PACK_UNSIGNED_WORD_TO_BYTE;
			OP_ADD_B:    opNxt = PO_ADD_WRAP_BYTE;
			OP_ADD_W:    opNxt = PO_ADD_WRAP_WORD;
			OP_ADD_D:    opNxt = PO_ADD_WRAP_DWORD;
			OP_ADDS_B:   opNxt = PO_ADD_SAT_SIGNED_BYTE;
			OP_ADDS_W:   opNxt = PO_ADD_SAT_SIGNED_WORD;
			OP_ADDUS_B:  opNxt = PO_ADD_SAT_UNSIGNED_BYTE;
			OP_ADDUS_W:  opNxt = PO_ADD_SAT_UNSIGNED_WORD;
			OP_AND:      opNxt = PO_BITWISE_AND_64;
			OP_ANDN:     opNxt = PO_BITWISE_AND_NOT_64;
			OP_OR:       opNxt = PO_BITWISE_OR_64;
			OP_XOR:      opNxt = PO_BITWISE_XOR_64;
			OP_CEQ_B:    opNxt = PO_COMPARE_EQUAL_BYTE;
			OP_CEQ_W:    opNxt = PO_COMPARE_EQUAL_WORD;
			OP_CEQ_D:    opNxt = PO_COMPARE_EQUAL_DWORD;
			OP_CGT_B:    opNxt = PO_COMPARE_GREATER_BYTE;
			OP_CGT_W:    opNxt = PO_COMPARE_GREATER_WORD;
			OP_CGT_D:    opNxt = PO_COMPARE_GREATER_DWORD;
			OP_MADD:     opNxt = PO_MULTIPLY_ADD_WORDS;
			OP_MULH:     opNxt = PO_MULTIPLY_HIGH_WORD;
			OP_MULL:     opNxt = PO_MULTIPLY_LOW_WORD;
			OP_SLL_W:    opNxt = PO_SHIFT_LEFT_WORD;
			OP_SLL_D:    opNxt = PO_SHIFT_LEFT_DWORD;
			OP_SLL_Q:    opNxt = PO_SHIFT_LEFT_QWORD;
			OP_SRA_W:    opNxt = PO_SHIFT_RIGHT_ARITH_WORD;
			OP_SRA_D:    opNxt = PO_SHIFT_RIGHT_ARITH_DWORD;
			OP_SRL_W:    opNxt = PO_SHIFT_RIGHT_LOGIC_WORD;
			OP_SRL_D:    opNxt = PO_SHIFT_RIGHT_LOGIC_DWORD;
			OP_SRL_Q:    opNxt = PO_SHIFT_RIGHT_LOGIC_QWORD;
			OP_SUB_B:    opNxt = PO_SUB_WRAP_BYTE;
			OP_SUB_W:    opNxt = PO_SUB_WRAP_WORD;
			OP_SUB_D:    opNxt = PO_SUB_WRAP_DWORD;
			OP_SUBS_B:   opNxt = PO_SUB_SAT_SIGNED_BYTE;
			OP_SUBS_W:   opNxt = PO_SUB_SAT_SIGNED_WORD;
			OP_SUBUS_B:  opNxt = PO_SUB_SAT_UNSIGNED_BYTE;
			OP_SUBUS_W:  opNxt = PO_SUB_SAT_UNSIGNED_WORD;
			OP_UNPH_B:   opNxt = PO_INTERLEAVE_HIGH_BYTES;
			OP_UNPH_W:   opNxt = PO_INTERLEAVE_HIGH_WORDS;
			OP_UNPH_D:   opNxt = PO_INTERLEAVE_HIGH_DWORDS;
			OP_UNPL_B:   opNxt = PO_INTERLEAVE_LOW_BYTES;
			OP_UNPL_W:   opNxt = PO_INTERLEAVE_LOW_WORDS;
			OP_UNPL_D:   opNxt = PO_INTERLEAVE_LOW_DWORDS;
			OP_IMM_W, OP_IMM_D, OP_IMM_Q: begin
				opNxt   = PO_NONE; // Resolved from ModR/M later
				formNxt = FM_IMM;
			end
			default: begin
				opNxt   = PO_NONE;
				formNxt = FM_NONE;
			end
		endcase
	end

	// Registered read data
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			opOut   <= PO_NONE;
			formOut <= FM_NONE;
		end else if (lookEn) begin
			opOut   <= opNxt;
			formOut <= formNxt;
		end
	end
endmodule : psd_op_table

// ==== hdl/psd_decoder.sv ====
// Purpose: Byte-serial decoder for the two-byte packed SIMD opcodes
// Assumes: Fetch presents one byte per cycle with byteValid, same clock
// Notes:   Output struct and strobes are registered; one result per instruction
`timescale 1ns/1ps

module psd_decoder
	import psd_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       byteValid,
	input  wire logic [7:0] byteIn,
	output psd_dec_t        decOut_r,
	output logic            decValid_r,
	output logic            passGeneral_r,
	output logic [7:0]      passByte_r,
	output logic            illegal_r
);
	typedef enum logic [7:0] {
		ST_IDLE   = 8'b0000_0001,
		ST_OP     = 8'b0000_0010,
		ST_LOOK   = 8'b0000_0100,
		ST_MODRM  = 8'b0000_1000,
		ST_SIB    = 8'b0001_0000,
		ST_DISP   = 8'b0010_0000,
		ST_IMM    = 8'b0100_0000,
		ST_FINISH = 8'b1000_0000
	} psd_state_t;

	psd_state_t state_r;
	psd_op_t    tblOp;
	psd_form_t  tblForm;
	psd_dec_t   work_r;
	logic [7:0] opByte_r;
	logic [2:0] dispLeft_r;
	logic       isOp;
	logic       pendByte_r;
	logic [7:0] pendVal_r;

	// Immediate shift group selection from opcode and ModR/M reg field
	function automatic psd_op_t immShift(input logic [7:0] op, input logic [7:0] mrm);
		logic [2:0] sel;
		sel = mrm[REG_HI:REG_LO];
		immShift = PO_NONE;
		if (mrm[MOD_HI:MOD_LO] == MOD_REGISTER) begin
			case (op)
				OP_IMM_W: begin
					case (sel)
						REG_SHL:  immShift = PO_SHIFT_LEFT_WORD;
						REG_SHRA: immShift = PO_SHIFT_RIGHT_ARITH_WORD;
						REG_SHRL: immShift = PO_SHIFT_RIGHT_LOGIC_WORD;
						default:  immShift = PO_NONE;
					endcase
				end
				OP_IMM_D: begin
					case (sel)
						REG_SHL:  immShift = PO_SHIFT_LEFT_DWORD;
						REG_SHRA: immShift = PO_SHIFT_RIGHT_ARITH_DWORD;
						REG_SHRL: immShift = PO_SHIFT_RIGHT_LOGIC_DWORD;
						default:  immShift = PO_NONE;
					endcase
				end
				OP_IMM_Q: begin
					case (sel)
						REG_SHL:  immShift = PO_SHIFT_LEFT_QWORD;
						REG_SHRL: immShift = PO_SHIFT_RIGHT_LOGIC_QWORD;
						default:  immShift = PO_NONE;
					endcase
				end
				default: immShift = PO_NONE;
			endcase
		end
	endfunction : immShift

	// Displacement bytes that follow ModR/M (and SIB) in 32-bit addressing
	function automatic logic [2:0] dispLen(input logic [7:0] mrm, input logic [2:0] base);
		dispLen = 3'h0;
		case (mrm[MOD_HI:MOD_LO])
			MOD_NO_DISP: begin
				if (mrm[RM_HI:RM_LO] == RM_DISP32 || base == SIB_BASE_NONE)
					dispLen = DISP32_LEN;
			end
			MOD_DISP8:    dispLen = DISP8_LEN;
			MOD_REGISTER: dispLen = 3'h0;
			default:      dispLen = DISP32_LEN;
		endcase
	endfunction : dispLen

	assign isOp = byteValid && (state_r == ST_OP);

	psd_op_table u_table (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.lookEn  (isOp),
		.opByte  (byteIn),
		.opOut   (tblOp),
		.formOut (tblForm)
	);

	// Sequencer over the instruction bytes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r    <= ST_IDLE;
			opByte_r   <= 8'h00;
			dispLeft_r <= 3'h0;
			work_r     <= '0;
			pendByte_r <= 1'b0;
			pendVal_r  <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (byteValid && byteIn == ESCAPE_BYTE)
						state_r <= ST_OP;
				end
				ST_OP: begin
					if (byteValid) begin
						opByte_r <= byteIn;
						state_r  <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					// Table answer arrives; a byte arriving meanwhile is held
					pendByte_r <= byteValid && (tblForm != FM_NONE); // Unlisted op keeps nothing queued
					pendVal_r  <= byteIn;
					work_r     <= '0;
					work_r.op  <= tblOp;
					if (tblForm == FM_NONE)
						state_r <= ST_IDLE;
					else
						state_r <= ST_MODRM;
				end
				ST_MODRM: begin
					if (pendByte_r || byteValid) begin
						work_r.modrm <= pendByte_r ? pendVal_r : byteIn;
						if (byteValid && pendByte_r) begin
							pendVal_r <= byteIn;
						end else begin
							pendByte_r <= 1'b0;
						end
						if (tblForm == FM_IMM) begin
							work_r.op <= immShift(opByte_r, pendByte_r ? pendVal_r : byteIn);
							state_r   <= ST_IMM;
						end else if ((pendByte_r ? pendVal_r[MOD_HI:MOD_LO] : byteIn[MOD_HI:MOD_LO]) != MOD_REGISTER
							&& (pendByte_r ? pendVal_r[RM_HI:RM_LO] : byteIn[RM_HI:RM_LO]) == RM_SIB) begin
							state_r <= ST_SIB;
						end else begin
							dispLeft_r <= dispLen(pendByte_r ? pendVal_r : byteIn, 3'h0);
							state_r    <= (dispLen(pendByte_r ? pendVal_r : byteIn, 3'h0) == 3'h0) ? ST_FINISH : ST_DISP;
						end
					end
				end
				ST_SIB: begin
					if (pendByte_r || byteValid) begin
						work_r.sib        <= pendByte_r ? pendVal_r : byteIn;
						work_r.sibPresent <= 1'b1;
						pendByte_r        <= pendByte_r && byteValid; // Byte behind the buffer stays queued
						pendVal_r         <= byteIn;
						dispLeft_r        <= dispLen(work_r.modrm, pendByte_r ? pendVal_r[RM_HI:RM_LO] : byteIn[RM_HI:RM_LO]);
						state_r           <= (dispLen(work_r.modrm, pendByte_r ? pendVal_r[RM_HI:RM_LO]
							: byteIn[RM_HI:RM_LO]) == 3'h0) ? ST_FINISH : ST_DISP;
					end
				end
				ST_DISP: begin
					// Displacement bytes are consumed, the datapath takes them from fetch
					if (pendByte_r || byteValid) begin
						pendByte_r <= pendByte_r && byteValid;
						pendVal_r  <= byteIn;
						dispLeft_r <= dispLeft_r - 3'h1;
						if (dispLeft_r == 3'h1)
							state_r <= ST_FINISH;
					end
				end
				ST_IMM: begin
					if (pendByte_r || byteValid) begin
						work_r.imm        <= pendByte_r ? pendVal_r : byteIn;
						work_r.immPresent <= 1'b1;
						pendByte_r        <= pendByte_r && byteValid;
						pendVal_r         <= byteIn;
						state_r           <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					// A queued byte is looked at first so nothing stale reaches the next instruction
					pendByte_r <= 1'b0;
					if (pendByte_r ? (pendVal_r == ESCAPE_BYTE) : (byteValid && byteIn == ESCAPE_BYTE))
						state_r <= ST_OP;
					else
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Result strobes towards the packed datapath
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			decOut_r   <= '0;
			decValid_r <= 1'b0;
			illegal_r  <= 1'b0;
		end else begin
			decValid_r <= 1'b0;
			illegal_r  <= 1'b0;
			if (state_r == ST_FINISH) begin
				decOut_r   <= work_r;
				decValid_r <= (work_r.op != PO_NONE);
				illegal_r  <= (work_r.op == PO_NONE); // Immediate form with non-register mod or bad shift select
			end
		end
	end

	// Unlisted escape opcodes handed to the general decoder
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			passGeneral_r <= 1'b0;
			passByte_r    <= 8'h00;
		end else begin
			passGeneral_r <= (state_r == ST_LOOK) && (tblForm == FM_NONE);
			// Byte only moves together with its pass strobe
			passByte_r    <= (state_r == ST_LOOK && tblForm == FM_NONE) ? opByte_r : passByte_r;
		end
	end
endmodule : psd_decoder

// ==== tb/psd_decoder_properties.sv ====
// Purpose: Concurrent checks on the packed opcode decoder ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every psd_decoder instance
`timescale 1ns/1ps
module psd_decoder_chk
	import psd_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       byteValid,
	input wire logic [7:0] byteIn,
	input wire psd_dec_t   decOut_r,
	input wire logic       decValid_r,
	input wire logic       passGeneral_r,
	input wire logic [7:0] passByte_r,
	input wire logic       illegal_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Reset clears every strobe
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !decValid_r && !passGeneral_r && !illegal_r)
		else $error("strobe high after reset");
	// Results are single-cycle pulses of one kind
	valid_pulse_a: assert property (decValid_r |=> !decValid_r) else $error("decValid longer than one cycle");
	result_excl_a: assert property (decValid_r |-> !passGeneral_r && !illegal_r) else $error("two result kinds");
	dec_hold_a: assert property (!decValid_r && !illegal_r |-> $stable(decOut_r)) else $error("decOut moved");
	pass_hold_a: assert property (!passGeneral_r |-> $stable(passByte_r)) else $error("passByte moved");
	valid_op_a: assert property (decValid_r |-> decOut_r.op != PO_NONE) else $error("valid with no op");
	imm_mod_a: assert property (decValid_r && decOut_r.immPresent |-> decOut_r.modrm[7:6] == MOD_REGISTER)
		else $error("immediate form without register mod");
	imm_select_a: assert property (decValid_r && decOut_r.immPresent |->
		(decOut_r.op inside {PO_SHIFT_LEFT_WORD, PO_SHIFT_LEFT_DWORD, PO_SHIFT_LEFT_QWORD}) ==
		(decOut_r.modrm[5:3] == REG_SHL)) else $error("shift select not from reg field");
	sib_need_a: assert property (decValid_r && decOut_r.sibPresent |->
		decOut_r.modrm[2:0] == RM_SIB && decOut_r.modrm[7:6] != MOD_REGISTER) else $error("SIB without need");
	pass_list_a: assert property (passGeneral_r |->
		!(passByte_r inside {8'h77, 8'h71, 8'h72, 8'h73, 8'hFC, 8'h6E, 8'hD5})) else $error("listed byte passed");
	pass_time_a: assert property ((byteValid && byteIn == ESCAPE_BYTE) ##1 (byteValid && byteIn == 8'h00) |->
		##[1:2] (passGeneral_r && passByte_r == 8'h00)) else $error("unlisted byte not passed");
endmodule : psd_decoder_chk

bind psd_decoder psd_decoder_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .byteValid(byteValid),
	.byteIn(byteIn), .decOut_r(decOut_r), .decValid_r(decValid_r), .passGeneral_r(passGeneral_r),
	.passByte_r(passByte_r), .illegal_r(illegal_r));

// ==== tb/psd_fetch_model.sv ====
// Purpose: Fetch queue model that offers instruction bytes one per cycle
// Assumes: send is entered just after a rising edge
// Notes:   Idle byte lines show the inverse of the last byte
`timescale 1ns/1ps
module psd_fetch_model (
	input  wire logic       ref_clk,
	output logic            byteValid,
	output logic [7:0]      byteIn
);
	// Idle at time zero
	initial begin
		byteValid = 1'b0;
		byteIn    = 8'h00;
	end

	// Offers n bytes taken from the top of seq, idle after the opcode byte when gap is set
	task automatic send(input logic [63:0] seq, input int n, input bit gap = 1'b1);
		int k;
		for (k = 0; k < n; k++) begin
			byteValid = 1'b1;
			byteIn    = seq[63 - 8 * k -: 8];
			@(posedge ref_clk);
			#1;
			if (gap && k == 1 && n > 2) begin
				byteValid = 1'b0;
				byteIn    = ~byteIn;
				@(posedge ref_clk);
				#1;
			end
		end
		byteValid = 1'b0;
		byteIn    = ~byteIn; // Released lines do not keep the last byte
	endtask : send
endmodule : psd_fetch_model

// ==== tb/psd_decoder_bench.sv ====
// Purpose: Self-checking bench for the packed opcode decoder
// Assumes: Fetch model drives bytes 1 ns after the rising edge
// Notes:   Each scenario task drives and judges its own traffic
`timescale 1ns/1ps
module psd_decoder_bench;
	import psd_pkg::*;
	logic       ref_clk;
	logic       sys_rst;
	logic       byteValid;
	logic [7:0] byteIn;
	psd_dec_t   decOut_r;
	logic       decValid_r;
	logic       passGeneral_r;
	logic [7:0] passByte_r;
	logic       illegal_r;
	int         miscompares;
	int         samples_checked;
	logic [2:0] kind;
	// Register-form second bytes in operation order
	logic [7:0] regOps [49] = '{8'h77, 8'h6E, 8'h7E, 8'h6F, 8'h7F, 8'h6B, 8'h63, 8'h67, 8'hFC, 8'hFD, 8'hFE,
		8'hEC, 8'hED, 8'hDC, 8'hDD, 8'hDB, 8'hDF, 8'hEB, 8'hEF, 8'h74, 8'h75, 8'h76, 8'h64, 8'h65, 8'h66,
		8'hF5, 8'hE5, 8'hD5, 8'hF1, 8'hF2, 8'hF3, 8'hE1, 8'hE2, 8'hD1, 8'hD2, 8'hD3, 8'hF8, 8'hF9, 8'hFA,
		8'hE8, 8'hE9, 8'hD8, 8'hD9, 8'h68, 8'h69, 8'h6A, 8'h60, 8'h61, 8'h62};
	logic [2:0] selReg [3] = '{3'h6, 3'h4, 3'h2};
	psd_op_t    expImm [9] = '{PO_SHIFT_LEFT_WORD, PO_SHIFT_RIGHT_ARITH_WORD, PO_SHIFT_RIGHT_LOGIC_WORD,
		PO_SHIFT_LEFT_DWORD, PO_SHIFT_RIGHT_ARITH_DWORD, PO_SHIFT_RIGHT_LOGIC_DWORD,
		PO_SHIFT_LEFT_QWORD, PO_NONE, PO_SHIFT_RIGHT_LOGIC_QWORD};

	psd_fetch_model fetch (.ref_clk(ref_clk), .byteValid(byteValid), .byteIn(byteIn));
	psd_decoder uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .byteValid(byteValid), .byteIn(byteIn),
		.decOut_r(decOut_r), .decValid_r(decValid_r), .passGeneral_r(passGeneral_r),
		.passByte_r(passByte_r), .illegal_r(illegal_r));

	// Clock at 125 MHz
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// Waits a bounded time for a result pulse: {illegal, pass, valid}
	task automatic wait_res;
		int i;
		kind = 3'h0;
		for (i = 0; i < 8 && kind == 3'h0; i++) begin
			@(posedge ref_clk);
			#1;
			kind = {illegal_r === 1'b1, passGeneral_r === 1'b1, decValid_r === 1'b1};
		end
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : wait_res

	// Every register-form opcode in register mode
	task automatic test_reg_ops;
		for (int i = 0; i < 49; i++) begin
			fetch.send({8'h0F, regOps[i], 8'hC1, 40'h0}, 3);
			wait_res();
			check("reg kind", kind, 3'h1);
			if (i < 28)
				check("reg op", decOut_r.op, psd_op_t'(i + 1));
			else
				check("reg op", decOut_r.op, psd_op_t'(i + 1));
			check("reg modrm", {decOut_r.modrm, decOut_r.sibPresent, decOut_r.immPresent}, 10'h304);
		end
	endtask : test_reg_ops

	// Immediate groups, every select, then bad mod and bad select
	task automatic test_imm;
		logic [7:0] mrm;
		for (int g = 0; g < 3; g++) begin
			for (int s = 0; s < 3; s++) begin
				mrm = {2'h3, selReg[s], 3'h1};
				fetch.send({8'h0F, 8'(8'h71 + g), mrm, 8'(8'h05 + s), 32'h0}, 4);
				wait_res();
				if (expImm[g * 3 + s] == PO_NONE) begin
					check("imm qword arith", kind, 3'h4);
				end else begin
					check("imm kind", kind, 3'h1);
					check("imm op", decOut_r.op, expImm[g * 3 + s]);
					check("imm data", {decOut_r.imm, decOut_r.immPresent}, {8'(8'h05 + s), 1'b1});
				end
			end
		end
		fetch.send({8'h0F, 8'h71, 8'h31, 8'h05, 32'h0}, 4);
		wait_res();
		check("imm bad mod", kind, 3'h4);
		fetch.send({8'h0F, 8'h72, 8'hC9, 8'h07, 32'h0}, 4);
		wait_res();
		check("imm bad reg", kind, 3'h4);
	endtask : test_imm

	// Memory forms with and without SIB and displacement
	task automatic mem_case(input logic [63:0] seq, input int n, input logic [8:0] expSib, input bit gap = 1'b1);
		fetch.send(seq, n, gap);
		wait_res();
		check("mem kind", kind, 3'h1);
		check("mem op", decOut_r.op, PO_ADD_WRAP_DWORD);
		check("mem sib", {decOut_r.sib, decOut_r.sibPresent}, expSib);
	endtask : mem_case

	task automatic test_mem;
		mem_case({8'h0F, 8'hFE, 8'h04, 8'h00, 32'h0}, 4, 9'h001);
		mem_case({8'h0F, 8'hFE, 8'h44, 8'h11, 8'h7A, 24'h0}, 5, 9'h023);
		mem_case({8'h0F, 8'hFE, 8'h05, 8'h12, 8'h34, 8'h56, 8'h78, 8'h0}, 7, 9'h000);
		mem_case({8'h0F, 8'hFE, 8'h84, 8'h22, 8'h9A, 8'hBC, 8'hDE, 8'hF0}, 8, 9'h045);
		mem_case({8'h0F, 8'hFE, 8'h04, 8'h25, 8'h11, 8'h22, 8'h33, 8'h44}, 8, 9'h04B);
		// Gapless streams lean on the one-byte buffer behind the lookup
		mem_case({8'h0F, 8'hFE, 8'h44, 8'h11, 8'h7A, 24'h0}, 5, 9'h023, 1'b0);
		mem_case({8'h0F, 8'hFE, 8'h84, 8'h22, 8'h9A, 8'hBC, 8'hDE, 8'hF0}, 8, 9'h045, 1'b0);
	endtask : test_mem

	// Unlisted second bytes go to the general decoder
	task automatic test_pass;
		logic [7:0] unl [5] = '{8'h00, 8'h0B, 8'hB9, 8'h70, 8'hFF};
		for (int i = 0; i < 5; i++) begin
			fetch.send({8'h0F, unl[i], 48'h0}, 2);
			wait_res();
			check("pass kind", kind, 3'h2);
			check("pass byte", passByte_r, unl[i]);
		end
	endtask : test_pass

	// Stray bytes ignored, reset mid-instruction abandons it
	task automatic test_reset;
		fetch.send({8'hFC, 8'hC1, 48'h0}, 2);
		wait_res();
		check("no escape", kind, 3'h0);
		fetch.send({8'h0F, 8'hFD, 48'h0}, 2);
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		check("rst strobes", {decValid_r, passGeneral_r, illegal_r}, 3'h0);
		sys_rst = 1'b0;
		fetch.send({8'hC1, 56'h0}, 1);
		wait_res();
		check("after rst", kind, 3'h0);
		fetch.send({8'h0F, 8'hFD, 8'hC1, 40'h0}, 3);
		wait_res();
		check("rst recover", decOut_r.op, PO_ADD_WRAP_WORD);
	endtask : test_reset

	// Watchdog
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end

	// Main sequence
	initial begin
		miscompares     = 0;
		samples_checked = 0;
		sys_rst         = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		test_reg_ops();
		test_imm();
		test_mem();
		test_pass();
		test_reset();
		give_verdict();
	end
endmodule : psd_decoder_bench
